// ==== design/pfpi_pkg.sv ====
// constants, types and pin bundle of the parallel flash program interface
// assumes a single 125 MHz clock and synchronous active-high reset
package pfpi_pkg;

    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 8192;
    localparam int CNT_W = 21;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;

    // timing at 125 MHz
    localparam int CLK_KHZ = 125000;
    localparam real WRITE_MAX_MS = 2.0;
    localparam real ERASE_MIN_MS = 10.0;
    localparam real BUSY_MAX_US = 1.0;
    localparam int WRITE_CYCLES = $rtoi($floor(WRITE_MAX_MS * CLK_KHZ));
    localparam int ERASE_CYCLES = $rtoi($ceil(ERASE_MIN_MS * CLK_KHZ));
    localparam int BUSY_LAT_CYCLES = $rtoi($floor(BUSY_MAX_US * CLK_KHZ / 1000.0));

    // select patterns {a, b, c, d}
    localparam logic [3:0] SEL_WRITE_CODE = 4'h7;
    localparam logic [3:0] SEL_READ_CODE = 4'h3;
    localparam logic [3:0] SEL_READ_SIG = 4'h0;
    localparam logic [3:0] SEL_LOCK_ONE = 4'hF;
    localparam logic [3:0] SEL_LOCK_TWO = 4'hC;
    localparam logic [3:0] SEL_LOCK_THREE = 4'hA;
    localparam logic [3:0] SEL_ERASE = 4'h8;

    // signature
    localparam logic [ADDR_W-1:0] SIG_MAKER_ADDR = 13'h0030;
    localparam logic [ADDR_W-1:0] SIG_PART_ADDR = 13'h0031;
    localparam logic [ADDR_W-1:0] SIG_VARIANT_ADDR = 13'h0032;
    localparam logic [DATA_W-1:0] SIG_VARIANT_HV = 8'hFF;
    localparam logic [DATA_W-1:0] SIG_VARIANT_LV = 8'h05;
    localparam logic [DATA_W-1:0] SIG_UNUSED = 8'hFF;

    // apb register map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam int CTRL_HV_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REFUSED_BIT = 1;
    localparam int STAT_EA_BIT = 2;
    localparam int STAT_ERASE_BIT = 3;
    localparam logic CTRL_HV_RESET = 1'b1;

    typedef enum logic [2:0] {
        MODE_IDLE = 3'b000,
        MODE_WRITE_CODE = 3'b001,
        MODE_READ_CODE = 3'b010,
        MODE_READ_SIG = 3'b011,
        MODE_LOCK_ONE = 3'b100,
        MODE_LOCK_TWO = 3'b101,
        MODE_LOCK_THREE = 3'b110,
        MODE_ERASE = 3'b111
    } pfpi_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01,
        ST_ERASE = 2'b10
    } pfpi_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data_in;
        logic mode_select_a;
        logic mode_select_b;
        logic mode_select_c;
        logic mode_select_d;
        logic program_strobe_n;
        logic code_fetch_strobe_n;
        logic reset_pin;
        logic access_level;
        logic access_hv;
    } pfpi_pins_t;

endpackage

// ==== design/pfpi_cycle_counter.sv ====
// saturating cycle counter that flags when a limit is reached
// assumes clear has priority over run
`timescale 1ns/1ps
`default_nettype none
module pfpi_cycle_counter (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic clear,
    input wire logic run,
    input wire logic [pfpi_pkg::CNT_W-1:0] limit,
    // result
    output logic reached
);
    import pfpi_pkg::*;

    logic [CNT_W-1:0] count_q;

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            count_q <= '0;
        end else if (run && !reached) begin
            count_q <= count_q + 1'b1;
        end
    end

    assign reached = (count_q >= limit);

endmodule // pfpi_cycle_counter
`default_nettype wire

// ==== design/pfpi_top.sv ====
// parallel flash program interface: code array, lock bits, programming pins, apb status
// assumes programming pins synchronous to clk; rst stands for factory-fresh power-on
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pfpi_top #(
    parameter int WRITE_CYCLES_P = pfpi_pkg::WRITE_CYCLES,
    parameter int ERASE_CYCLES_P = pfpi_pkg::ERASE_CYCLES,
    parameter logic [7:0] MAKER_CODE = 8'hA5,  // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h3C    // arbitrary value
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // programming pins
    input wire pfpi_pkg::pfpi_pins_t pins,
    output logic [pfpi_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic ready_busy_pin,
    // core-side restrictions
    output logic code_table_read_internal_enable,
    output logic external_exec_enable,
    output logic external_access_latched
);
    import pfpi_pkg::*;

    function automatic pfpi_mode_t decode_mode(input pfpi_pins_t p);
        logic [3:0] sel;
        sel = {p.mode_select_a, p.mode_select_b, p.mode_select_c, p.mode_select_d};
        if (!p.reset_pin || p.code_fetch_strobe_n) begin
            decode_mode = MODE_IDLE;
        end else if (sel == SEL_WRITE_CODE) begin
            decode_mode = MODE_WRITE_CODE;
        end else if (sel == SEL_READ_CODE) begin
            decode_mode = MODE_READ_CODE;
        end else if (sel == SEL_READ_SIG) begin
            decode_mode = MODE_READ_SIG;
        end else if (sel == SEL_LOCK_ONE) begin
            decode_mode = MODE_LOCK_ONE;
        end else if (sel == SEL_LOCK_TWO) begin
            decode_mode = MODE_LOCK_TWO;
        end else if (sel == SEL_LOCK_THREE) begin
            decode_mode = MODE_LOCK_THREE;
        end else if (sel == SEL_ERASE) begin
            decode_mode = MODE_ERASE;
        end else begin
            decode_mode = MODE_IDLE;
        end
    endfunction

    // storage
    logic [DATA_W-1:0] mem_q [MEM_DEPTH];
    logic [2:0] lock_q;

    // control state
    pfpi_state_t state_q;
    pfpi_mode_t op_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [DATA_W-1:0] wr_data_q;
    logic strobe_q;
    logic hv_q;
    logic refused_q;
    logic erased_q;
    logic ea_q;
    logic [31:0] prdata_q;

    // combinational terms
    pfpi_mode_t mode;
    logic enable_ok;
    logic strobe_rise;
    logic write_req;
    logic write_refused;
    logic start_write;
    logic write_done;
    logic erase_arm;
    logic erase_reached;
    logic erase_go;
    logic verify_blocked;
    logic apb_setup;
    logic apb_access;
    logic addr_hit;

    assign mode = decode_mode(pins);

    // variant chooses which enable level counts
    assign enable_ok = hv_q ? pins.access_hv : pins.access_level;

    assign strobe_rise = !strobe_q && pins.program_strobe_n;

    assign write_req = strobe_rise && enable_ok && (state_q == ST_IDLE) &&
                       (mode == MODE_WRITE_CODE || mode == MODE_LOCK_ONE ||
                        mode == MODE_LOCK_TWO || mode == MODE_LOCK_THREE);

    // code writes refused once lock bit one is set, strobes while busy refused too
    assign write_refused = (write_req && mode == MODE_WRITE_CODE && lock_q[0]) ||
                           (strobe_rise && state_q != ST_IDLE);

    assign start_write = write_req && !write_refused;

    assign verify_blocked = lock_q[0] || lock_q[1];

    // erase counts only while the strobe is held low with a valid enable
    assign erase_arm = (state_q == ST_IDLE) && (mode == MODE_ERASE) &&
                       !pins.program_strobe_n && enable_ok;
    assign erase_go = erase_arm && erase_reached;

    always_ff @(posedge clk) begin
        if (rst) begin
            strobe_q <= 1'b1;
        end else begin
            strobe_q <= pins.program_strobe_n;
        end
    end

    // self-timed write cycle
    pfpi_cycle_counter u_write_timer (
        .clk(clk),
        .rst(rst),
        .clear(state_q != ST_WRITE),
        .run(state_q == ST_WRITE),
        .limit(CNT_W'(WRITE_CYCLES_P)),
        .reached(write_done)
    );

    // strobe-low duration for chip erase
    pfpi_cycle_counter u_erase_timer (
        .clk(clk),
        .rst(rst),
        .clear(!erase_arm),
        .run(1'b1),
        .limit(CNT_W'(ERASE_CYCLES_P)),
        .reached(erase_reached)
    );

    // sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_write) begin
                        state_q <= ST_WRITE;
                    end else if (erase_go) begin
                        state_q <= ST_ERASE;
                    end
                end
                ST_WRITE: begin
                    if (write_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_ERASE: begin
                    // one erase per low pulse
                    if (pins.program_strobe_n) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // operation captured at the strobe edge
    always_ff @(posedge clk) begin
        if (rst) begin
            op_q <= MODE_IDLE;
            wr_addr_q <= '0;
            wr_data_q <= '0;
        end else if (start_write) begin
            op_q <= mode;
            wr_addr_q <= pins.addr;
            wr_data_q <= pins.data_in;
        end
    end

    // code array
    always_ff @(posedge clk) begin
        if (rst || erase_go) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_q[i] <= ERASED_BYTE;
            end
        end else if (state_q == ST_WRITE && write_done && op_q == MODE_WRITE_CODE) begin
            mem_q[wr_addr_q] <= wr_data_q;
        end
    end

    // lock bits, cleared only by reset and chip erase and never readable
    always_ff @(posedge clk) begin
        if (rst || erase_go) begin
            lock_q <= 3'h0;
        end else if (state_q == ST_WRITE && write_done) begin
            if (op_q == MODE_LOCK_ONE) begin
                lock_q[0] <= 1'b1;
            end else if (op_q == MODE_LOCK_TWO) begin
                lock_q[1] <= 1'b1;
            end else if (op_q == MODE_LOCK_THREE) begin
                lock_q[2] <= 1'b1;
            end
        end
    end

    // access pin latch, follows the pin while the reset pin is high and lock bit one is set
    always_ff @(posedge clk) begin
        if (rst) begin
            ea_q <= 1'b0;
        end else if (pins.reset_pin && lock_q[0]) begin
            ea_q <= pins.access_level;
        end
    end

    // data lines
    always_ff @(posedge clk) begin
        if (rst) begin
            data_out <= '0;
            data_oe <= 1'b0;
        end else if (mode == MODE_READ_CODE && state_q == ST_WRITE &&
                     pins.addr == wr_addr_q) begin
            data_out <= {~wr_data_q[DATA_W-1], wr_data_q[DATA_W-2:0]};
            data_oe <= 1'b1;
        end else if (mode == MODE_READ_CODE && !verify_blocked) begin
            data_out <= mem_q[pins.addr];
            data_oe <= 1'b1;
        end else if (mode == MODE_READ_SIG) begin
            data_oe <= 1'b1;
            if (pins.addr == SIG_MAKER_ADDR) begin
                data_out <= MAKER_CODE;
            end else if (pins.addr == SIG_PART_ADDR) begin
                data_out <= PART_CODE;
            end else if (pins.addr == SIG_VARIANT_ADDR) begin
                data_out <= hv_q ? SIG_VARIANT_HV : SIG_VARIANT_LV;
            end else begin
                data_out <= SIG_UNUSED;
            end
        end else begin
            data_out <= '0;
            data_oe <= 1'b0;
        end
    end

    // busy shows one edge after the strobe rises, well inside the limit
    assign ready_busy_pin = (state_q != ST_WRITE);

    // core-side restrictions
    assign code_table_read_internal_enable = !lock_q[0];
    assign external_exec_enable = !lock_q[2];
    assign external_access_latched = ea_q;

    // apb slave, zero wait states
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign addr_hit = (paddr == REG_CTRL) || (paddr == REG_STATUS);
    assign pready = apb_access;
    assign pslverr = apb_access && !addr_hit;
    assign prdata = prdata_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_q <= '0;
        end else if (apb_setup && !pwrite) begin
            prdata_q <= '0;
            if (paddr == REG_CTRL) begin
                prdata_q[CTRL_HV_BIT] <= hv_q;
            end else if (paddr == REG_STATUS) begin
                prdata_q[STAT_BUSY_BIT] <= (state_q == ST_WRITE);
                prdata_q[STAT_REFUSED_BIT] <= refused_q;
                prdata_q[STAT_EA_BIT] <= ea_q;
                prdata_q[STAT_ERASE_BIT] <= erased_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hv_q <= CTRL_HV_RESET;
        end else if (apb_access && pwrite && paddr == REG_CTRL) begin
            hv_q <= pwdata[CTRL_HV_BIT];
        end
    end

    // sticky flags, a new event beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            refused_q <= 1'b0;
        end else if (write_refused) begin
            refused_q <= 1'b1;
        end else if (apb_access && pwrite && paddr == REG_STATUS && pwdata[STAT_REFUSED_BIT]) begin
            refused_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            erased_q <= 1'b0;
        end else if (erase_go) begin
            erased_q <= 1'b1;
        end else if (apb_access && pwrite && paddr == REG_STATUS && pwdata[STAT_ERASE_BIT]) begin
            erased_q <= 1'b0;
        end
    end

endmodule // pfpi_top
`default_nettype wire

// ==== test/pfpi_checker.sv ====
// concurrent checks on the programming pins of pfpi_top
// assumes it is bound into pfpi_top, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module pfpi_checker #(
    parameter int WRITE_CYCLES_P = 20,
    parameter logic [7:0] MAKER_CODE = 8'h00,
    parameter logic [7:0] PART_CODE = 8'h00
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // programming pins
    input wire pfpi_pkg::pfpi_pins_t pins,
    input wire logic [pfpi_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic ready_busy_pin,
    // core-side restrictions
    input wire logic code_table_read_internal_enable,
    input wire logic external_exec_enable,
    input wire logic external_access_latched
);
    import pfpi_pkg::*;
    logic [3:0] sel;
    logic rise, rd_ok, strobe_q, poll_q, sig_q, lock_rd_q, wr_bit7_q;
    logic [15:0] low_cnt_q;
    logic [ADDR_W-1:0] wr_addr_q, sig_addr_q, cand_addr_q;
    logic rb_q, cand_code_q, cand_bit7_q, wr_valid_q;
    assign sel = {pins.mode_select_a, pins.mode_select_b, pins.mode_select_c, pins.mode_select_d};
    assign rise = pins.program_strobe_n & ~strobe_q;
    assign rd_ok = pins.reset_pin & ~pins.code_fetch_strobe_n;
    always_ff @(posedge clk) begin
        strobe_q <= pins.program_strobe_n;
    end
    // length of the current busy phase
    always_ff @(posedge clk) begin
        low_cnt_q <= (rst || ready_busy_pin) ? 16'h0000 : low_cnt_q + 16'h0001;
    end
    // strobe candidate, committed only once busy really starts (refused strobes never count)
    always_ff @(posedge clk) begin
        rb_q <= ready_busy_pin;
        if (rise && ready_busy_pin) begin
            cand_addr_q <= pins.addr;
            cand_bit7_q <= pins.data_in[7];
            cand_code_q <= (sel == SEL_WRITE_CODE);
        end
        if (rst) begin
            wr_valid_q <= 1'b0;
        end else if (rb_q && !ready_busy_pin) begin
            wr_valid_q <= cand_code_q;
            wr_addr_q <= cand_addr_q;
            wr_bit7_q <= cand_bit7_q;
        end
    end
    // reads whose answer shows one cycle later
    always_ff @(posedge clk) begin
        poll_q <= rd_ok && sel == SEL_READ_CODE && !ready_busy_pin && wr_valid_q && pins.addr == wr_addr_q;
        lock_rd_q <= rd_ok && sel == SEL_READ_CODE && ready_busy_pin && !code_table_read_internal_enable;
        sig_q <= rd_ok && sel == SEL_READ_SIG && !rst;
        sig_addr_q <= pins.addr;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence locked_write_s;
        rise && ready_busy_pin && !code_table_read_internal_enable && rd_ok && sel == SEL_WRITE_CODE;
    endsequence
    fresh_unlocked_a: assert property ($fell(rst) |-> code_table_read_internal_enable && external_exec_enable)
        else $error("restriction active after reset");
    busy_latency_a: assert property ($fell(ready_busy_pin) |-> $past(rise) || $past(rise, 2))
        else $error("busy without recent strobe");
    write_time_a: assert property ($rose(ready_busy_pin) |-> low_cnt_q == WRITE_CYCLES_P + 1)
        else $error("write cycle length wrong");
    poll_bit_a: assert property (poll_q && !ready_busy_pin |-> data_oe && data_out[7] == !wr_bit7_q)
        else $error("polling bit not inverted");
    sig_code_a: assert property (sig_q && sig_addr_q[12:1] == SIG_MAKER_ADDR[12:1] |->
        data_oe && data_out == (sig_addr_q[0] ? PART_CODE : MAKER_CODE)) else $error("signature wrong");
    locked_write_a: assert property (locked_write_s |=> ready_busy_pin [*3])
        else $error("locked write started");
    verify_block_a: assert property (lock_rd_q |-> !data_oe)
        else $error("read-back while locked");
    latch_follow_a: assert property (!code_table_read_internal_enable && pins.reset_pin |=>
        external_access_latched == $past(pins.access_level)) else $error("access latch stale");
endmodule // pfpi_checker
`default_nettype wire

// ==== test/pfpi_programmer_model.sv ====
// programmer model driving the programming pins of pfpi_top
// assumes its tasks are called by the bench, one at a time
`timescale 1ns/1ps
`default_nettype none
module pfpi_programmer_model (
    // clock
    input wire logic clk,
    // programming pins
    output var pfpi_pkg::pfpi_pins_t pins
);
    import pfpi_pkg::*;
    initial begin
        pins = '0;
        pins.program_strobe_n = 1'b1;
        pins.reset_pin = 1'b1;
        pins.access_level = 1'b1;
    end
    // address, data, select, enable, then one strobe held low for low cycles
    task automatic prog(input logic [3:0] sel, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic hv, input int low);
        @(posedge clk) pins.addr <= a;
        @(posedge clk) pins.data_in <= d;
        @(posedge clk) {pins.mode_select_a, pins.mode_select_b, pins.mode_select_c, pins.mode_select_d} <= sel;
        @(posedge clk) pins.access_hv <= hv;
        @(posedge clk) pins.program_strobe_n <= 1'b0;
        repeat (low) @(posedge clk);
        pins.program_strobe_n <= 1'b1;
        @(posedge clk) pins.data_in <= ~d;
    endtask
    // read: data inputs inverted, answer sampled on the falling edge
    task automatic look(input logic [3:0] sel, input logic [ADDR_W-1:0] a);
        @(posedge clk) pins.addr <= a;
        {pins.mode_select_a, pins.mode_select_b, pins.mode_select_c, pins.mode_select_d} <= sel;
        pins.data_in <= ~pins.data_in;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
endmodule // pfpi_programmer_model
`default_nettype wire

// ==== test/pfpi_bench.sv ====
// self-checking bench for pfpi_top: apb master, programmer model
// assumes shortened write and erase counts
`timescale 1ns/1ps
`default_nettype none
module pfpi_bench;
    import pfpi_pkg::*;
    localparam int WR_P = 20;
    localparam int ER_P = 50;
    localparam logic [7:0] MK = 8'h5A;  // arbitrary value
    localparam logic [7:0] PT = 8'hC3;  // arbitrary value
    logic clk, rst, psel, penable, pwrite, pready, pslverr, data_oe, ready_busy_pin, err;
    logic code_table_read_internal_enable, external_exec_enable, external_access_latched;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [DATA_W-1:0] data_out, d;
    logic [ADDR_W-1:0] a;
    pfpi_pins_t pins;
    integer seed = 31546;
    int fail_count = 0;
    int check_count = 0;
    pfpi_top #(.WRITE_CYCLES_P(WR_P), .ERASE_CYCLES_P(ER_P), .MAKER_CODE(MK), .PART_CODE(PT)) i_pfpi_top (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .data_out(data_out), .data_oe(data_oe), .ready_busy_pin(ready_busy_pin),
        .code_table_read_internal_enable(code_table_read_internal_enable), .external_exec_enable(external_exec_enable),
        .external_access_latched(external_access_latched));
    pfpi_programmer_model i_pfpi_programmer_model (.clk(clk), .pins(pins));
    always #4 clk = ~clk;
    function automatic logic [7:0] sig_exp(input int k, input logic hv);
        return k == 0 ? MK : k == 1 ? PT : hv ? SIG_VARIANT_HV : SIG_VARIANT_LV;
    endfunction
    task automatic stop_test();
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ready_busy_pin !== 1'b1 && n < 100);
        if (n >= 100) begin
            fail_count++;
            stop_test();
        end
    endtask
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            i_pfpi_programmer_model.look(SEL_READ_CODE, ADDR_W'($random(seed)));
            check({data_oe, data_out}, {1'b1, ERASED_BYTE});
        end
        apb(1'b0, 12'h008, 32'h0000_0000);
        check({err, rd}, {1'b1, 32'h0000_0000});
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? '1 : ADDR_W'($random(seed));
            d = (i == 1) ? 8'h00 : DATA_W'($random(seed));
            i_pfpi_programmer_model.prog(SEL_WRITE_CODE, a, d, 1'b1, 1);
            i_pfpi_programmer_model.look(SEL_READ_CODE, a);
            check({data_oe, data_out}, {1'b1, ~d[7], d[6:0]});
            apb(1'b0, REG_STATUS, 32'h0000_0000);
            check(rd[STAT_BUSY_BIT], 1'b1);
            wait_ready();
            i_pfpi_programmer_model.look(SEL_READ_CODE, a);
            check({data_oe, data_out}, {1'b1, d});
        end
        i_pfpi_programmer_model.prog(SEL_WRITE_CODE, 13'h0100, 8'h5A, 1'b1, 1);
        i_pfpi_programmer_model.prog(SEL_WRITE_CODE, 13'h0101, 8'h11, 1'b1, 1);
        wait_ready();
        i_pfpi_programmer_model.look(SEL_READ_CODE, 13'h0101);
        check({data_oe, data_out}, {1'b1, ERASED_BYTE});
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        check(rd[STAT_REFUSED_BIT], 1'b1);
        apb(1'b1, REG_STATUS, 32'h0000_0001 << STAT_REFUSED_BIT);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        check(rd[STAT_REFUSED_BIT], 1'b0);
        i_pfpi_programmer_model.prog(SEL_WRITE_CODE, 13'h0200, 8'h33, 1'b0, 1);
        repeat (3) @(negedge clk);
        check(ready_busy_pin, 1'b1);
        for (int v = 0; v < 2; v++) begin
            apb(1'b1, REG_CTRL, {31'h0000_0000, v == 0});
            for (int k = 0; k < 3; k++) begin
                i_pfpi_programmer_model.look(SEL_READ_SIG, SIG_MAKER_ADDR + ADDR_W'(k));
                check({data_oe, data_out}, {1'b1, sig_exp(k, v == 0)});
            end
        end
        for (int m = 0; m < 3; m++) begin
            i_pfpi_programmer_model.prog(m == 0 ? SEL_LOCK_ONE : m == 1 ? SEL_LOCK_TWO : SEL_LOCK_THREE,
                                         13'h0000, 8'h00, 1'b0, 1);
            wait_ready();
            check({code_table_read_internal_enable, external_exec_enable}, {1'b0, m != 2});
        end
        check(external_access_latched, 1'b1);
        i_pfpi_programmer_model.prog(SEL_WRITE_CODE, 13'h0300, 8'h44, 1'b0, 1);
        repeat (3) @(negedge clk);
        check(ready_busy_pin, 1'b1);
        i_pfpi_programmer_model.look(SEL_READ_CODE, a);
        check(data_oe, 1'b0);
        i_pfpi_programmer_model.prog(SEL_ERASE, 13'h0000, 8'h00, 1'b0, ER_P + 10);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        check(rd[STAT_ERASE_BIT], 1'b1);
        check({code_table_read_internal_enable, external_exec_enable}, 2'b11);
        i_pfpi_programmer_model.look(SEL_READ_CODE, a);
        check({data_oe, data_out}, {1'b1, ERASED_BYTE});
        i_pfpi_programmer_model.prog(SEL_WRITE_CODE, a, ~d, 1'b0, 1);
        wait_ready();
        i_pfpi_programmer_model.look(SEL_READ_CODE, a);
        check({data_oe, data_out}, {1'b1, ~d});
        stop_test();
    end
endmodule // pfpi_bench
bind pfpi_top pfpi_checker #(.WRITE_CYCLES_P(WRITE_CYCLES_P), .MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE))
    i_pfpi_checker (.clk(clk), .rst(rst), .pins(pins), .data_out(data_out), .data_oe(data_oe),
    .ready_busy_pin(ready_busy_pin), .code_table_read_internal_enable(code_table_read_internal_enable),
    .external_exec_enable(external_exec_enable), .external_access_latched(external_access_latched));
`default_nettype wire
